// ==== rtl/burst_modulation_control.sv ====
// burst modulation controller: triggered and gated carrier bursts
`timescale 1ns/10ps
`include "burst_consts.svh"
module burst_modulation_control #(
  parameter logic [33:0] INTERVAL_MIN_CYCLES     = 34'(`INTERVAL_MIN_US * `CLK_HZ / 64'd1000000),
  parameter logic [33:0] INTERVAL_MAX_CYCLES     = 34'(`INTERVAL_MAX_S * `CLK_HZ),
  parameter logic [33:0] INTERVAL_DEFAULT_CYCLES = 34'(`INTERVAL_DEFAULT_MS * `CLK_HZ / 64'd1000)
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // parameter settings
  input  wire logic                       set_burst_cycle_count,
  input  wire logic [15:0]                burst_cycle_count_value,
  input  wire logic                       set_burst_start_phase,
  input  wire logic [19:0]                burst_start_phase_value,
  input  wire logic                       set_internal_burst_interval,
  input  wire logic [33:0]                burst_interval_value,
  input  wire logic                       set_carrier,
  input  wire logic [32:0]                carrier_frequency_value,
  input  wire burst_pkg::shape_type       carrier_shape_value,
  input  wire logic                       request_is_remote,
  // mode selection
  input  wire logic                       select_burst_gate_source,
  input  wire burst_pkg::gate_source_type gate_source_value,
  input  wire logic                       set_trigger_source,
  input  wire burst_pkg::trig_source_type trigger_source_value,
  input  wire logic                       burst_mode_switch,
  input  wire logic                       burst_mode_on_value,
  input  wire logic                       enable_other_mode,
  input  wire burst_pkg::mod_mode_type    other_mode_value,
  input  wire logic                       apply_setup,
  // triggers and carrier timing
  input  wire logic                       ext_trigger_pin,
  input  wire logic                       bus_trigger,
  input  wire logic                       carrier_cycle_done,
  // common commands
  input  wire logic                       opc_query,
  input  wire logic                       opc_command,
  input  wire logic                       wai_command,
  input  wire logic                       opc_event_clear,
  // carrier control
  output burst_pkg::mod_mode_type         active_mode,
  output logic                            carrier_enable,
  output logic                            phase_load,
  output logic [19:0]                     start_phase,
  output logic                            phase_ref_first_sample,
  // status
  output logic                            trig_waiting,
  output logic                            burst_busy,
  output logic                            command_hold,
  output logic                            opc_reply_valid,
  output logic                            opc_event,
  output logic                            settings_conflict,
  output logic [15:0]                     burst_cycle_count,
  output logic [32:0]                     carrier_frequency,
  output logic [33:0]                     burst_interval,
  output burst_pkg::shape_type            carrier_shape
);
  import burst_pkg::*;

  burst_state_type state;
  burst_state_type next_state;
  logic            rst_n;
  logic            ext_level;

  // reset release through two flops
  sync_two_flop reset_sync (
    .clk   (clk),
    .rst_n (reset_n),
    .d     (1'b1),
    .q     (rst_n)
  );

  sync_two_flop ext_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (ext_trigger_pin),
    .q     (ext_level)
  );

  function automatic logic is_slow_shape(input shape_type sh);
    return (sh == SHAPE_TRI) || (sh == SHAPE_RAMP);
  endfunction

  // range limit for the carrier in burst mode
  function automatic logic [32:0] range_freq(input logic [32:0] f, input shape_type sh);
    logic [32:0] r;
    r = f;
    if (r < `FREQ_MIN) begin
      r = `FREQ_MIN;
    end
    if (is_slow_shape(sh) && r > `FREQ_MAX_TRI) begin
      r = `FREQ_MAX_TRI;
    end else if (r > `FREQ_MAX) begin
      r = `FREQ_MAX;
    end
    return r;
  endfunction

  // carrier limit imposed by the present burst count
  function automatic logic [32:0] count_freq(input logic [32:0] f, input logic [15:0] cnt,
                                             input shape_type sh);
    logic [32:0] hi;
    logic [32:0] lo;
    logic [32:0] r;
    hi = (cnt >= `COUNT_PER_MHZ_LIMIT) ? `FREQ_MAX : 33'(cnt) * `FREQ_ONE_MHZ;
    lo = 33'(cnt) * 33'(`MILLI_PER_UNIT / `BURST_DURATION_MAX_S);
    r = f;
    if (!is_slow_shape(sh) && r > hi) begin
      r = hi;
    end
    if (r <= `FREQ_LOW_LIMIT && r < lo) begin
      r = lo;
    end
    return r;
  endfunction

  always_comb begin
    logic        triggered;
    logic        gated;
    logic        ext_rise;
    logic        done;
    logic        pending;
    logic [15:0] cnt;
    logic [32:0] f_range;
    logic [32:0] f_legal;
    shape_type   sh;
    triggered = 1'b0;
    gated = 1'b0;
    ext_rise = 1'b0;
    done = 1'b0;
    pending = 1'b0;
    cnt = state.count;
    f_range = state.freq;
    f_legal = state.freq;
    sh = state.shape;
    next_state = state;
    next_state.phase_load = 1'b0;
    next_state.opc_reply_valid = 1'b0;
    next_state.conflict = 1'b0;

    // parameter writes
    if (set_burst_cycle_count) begin
      cnt = burst_cycle_count_value;
      if (cnt < `COUNT_MIN) begin
        cnt = `COUNT_MIN;
      end else if (cnt > `COUNT_MAX) begin
        cnt = `COUNT_MAX;
      end
      next_state.count = cnt;
    end
    if (set_carrier) begin
      sh = carrier_shape_value;
      f_range = range_freq(carrier_frequency_value, sh);
    end
    if (set_carrier || set_burst_cycle_count) begin
      f_legal = count_freq(f_range, cnt, sh);
      next_state.freq = f_legal;
      next_state.shape = sh;
      next_state.conflict = (f_legal != f_range) && request_is_remote;
    end
    if (set_burst_start_phase) begin
      if ($signed(burst_start_phase_value) > `PHASE_MAX) begin
        next_state.phase = `PHASE_MAX;
      end else if ($signed(burst_start_phase_value) < `PHASE_MIN) begin
        next_state.phase = `PHASE_MIN;
      end else begin
        next_state.phase = burst_start_phase_value;
      end
    end
    if (set_internal_burst_interval) begin
      if (burst_interval_value < INTERVAL_MIN_CYCLES) begin
        next_state.interval = INTERVAL_MIN_CYCLES;
      end else if (burst_interval_value > INTERVAL_MAX_CYCLES) begin
        next_state.interval = INTERVAL_MAX_CYCLES;
      end else begin
        next_state.interval = burst_interval_value;
      end
    end

    // mode and source selection
    if (select_burst_gate_source) begin
      next_state.gate_src = gate_source_value;
    end
    if (apply_setup) begin
      next_state.trig_src = TRIG_IMMEDIATE;
    end else if (set_trigger_source) begin
      next_state.trig_src = trigger_source_value;
    end
    if (burst_mode_switch) begin
      if (burst_mode_on_value) begin
        next_state.active_mode = MODE_BURST;
      end else if (state.active_mode == MODE_BURST) begin
        next_state.active_mode = MODE_NONE;
      end
    end else if (enable_other_mode) begin
      next_state.active_mode = other_mode_value;
    end

    triggered = (state.active_mode == MODE_BURST) && (state.gate_src == GATE_INTERNAL);
    gated = (state.active_mode == MODE_BURST) && (state.gate_src == GATE_EXTERNAL);
    ext_rise = ext_level && !state.ext_prev;
    next_state.ext_prev = ext_level;

    if (!triggered) begin
      // gating or a non-burst mode overrides every triggered setting
      next_state.busy = 1'b0;
      next_state.imm_pend = 1'b0;
      next_state.bus_pend = 1'b0;
      next_state.timer = '0;
      next_state.carrier_enable = gated ? ext_level : 1'b1;
    end else begin
      // internal rate timer, running only under the immediate source
      if (state.trig_src == TRIG_IMMEDIATE) begin
        if (state.timer >= state.interval - 34'h000000001) begin
          next_state.timer = '0;
          next_state.imm_pend = 1'b1;
        end else begin
          next_state.timer = state.timer + 34'h000000001;
        end
      end else begin
        next_state.timer = '0;
        next_state.imm_pend = 1'b0;
      end
      if (bus_trigger && state.trig_src == TRIG_BUS) begin
        next_state.bus_pend = 1'b1;
      end

      if (state.busy) begin
        if (carrier_cycle_done) begin
          if (state.remaining <= 16'h0001) begin
            next_state.busy = 1'b0;
            next_state.carrier_enable = 1'b0;
            done = 1'b1;
          end else begin
            next_state.remaining = state.remaining - 16'h0001;
          end
        end
      end else begin
        // a late timer tick waits here, giving back to back bursts
        if ((state.trig_src == TRIG_IMMEDIATE && state.imm_pend) ||
            (state.trig_src == TRIG_EXTERNAL && ext_rise) ||
            (state.trig_src == TRIG_BUS && state.bus_pend)) begin
          next_state.busy = 1'b1;
          next_state.remaining = state.count;
          next_state.phase_load = 1'b1;
          next_state.carrier_enable = 1'b1;
          if (state.trig_src == TRIG_IMMEDIATE) begin
            next_state.imm_pend = 1'b0;
          end
          if (state.trig_src == TRIG_BUS) begin
            next_state.bus_pend = bus_trigger;
          end
        end else begin
          next_state.carrier_enable = 1'b0;
        end
      end
    end
    next_state.trig_waiting = triggered && (state.trig_src == TRIG_EXTERNAL) &&
                              !next_state.busy;

    // operation complete and wait handling
    pending = next_state.busy || next_state.bus_pend;
    if (opc_query && !pending) begin
      next_state.opc_reply_valid = 1'b1;
    end else if (opc_query) begin
      next_state.opc_query_armed = 1'b1;
    end else if (state.opc_query_armed && (done || !pending)) begin
      next_state.opc_query_armed = 1'b0;
      next_state.opc_reply_valid = 1'b1;
    end
    if (opc_command) begin
      next_state.opc_cmd_armed = pending;
    end
    // a set in the clearing cycle wins
    if ((opc_command && !pending) || (state.opc_cmd_armed && (done || !pending))) begin
      next_state.opc_event = 1'b1;
      next_state.opc_cmd_armed = 1'b0;
    end else if (opc_event_clear) begin
      next_state.opc_event = 1'b0;
    end
    if (wai_command) begin
      next_state.wai_armed = pending;
    end else if (!pending) begin
      next_state.wai_armed = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state                 <= '0;
      state.active_mode     <= MODE_NONE;
      state.gate_src        <= GATE_INTERNAL;
      state.trig_src        <= TRIG_IMMEDIATE;
      state.shape           <= SHAPE_SINE;
      state.count           <= `COUNT_DEFAULT;
      state.freq            <= `FREQ_DEFAULT;
      state.phase           <= `PHASE_DEFAULT;
      state.interval        <= INTERVAL_DEFAULT_CYCLES;
      state.carrier_enable  <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign active_mode = state.active_mode;
  assign carrier_enable = state.carrier_enable;
  assign phase_load = state.phase_load;
  assign start_phase = state.phase;
  assign phase_ref_first_sample = (state.shape == SHAPE_ARB);
  assign trig_waiting = state.trig_waiting;
  assign burst_busy = state.busy;
  assign command_hold = state.wai_armed;
  assign opc_reply_valid = state.opc_reply_valid;
  assign opc_event = state.opc_event;
  assign settings_conflict = state.conflict;
  assign burst_cycle_count = state.count;
  assign carrier_frequency = state.freq;
  assign burst_interval = state.interval;
  assign carrier_shape = state.shape;
endmodule

// ==== rtl/burst_consts.svh ====
// constants for the burst modulation controller
// Contract
// - burst count 1 to 50000, default one
// - carrier limited 10 mHz to 5 MHz
// - count covers carrier in started MHz
// - high carrier clamped, remote conflict
// - low carrier burst lasts at most 500 s
// - low carrier raised, remote conflict
// - start phase within plus minus 360 degrees
// - zero phase at rising crossing or sample
// - internal burst interval 10 mHz to 50 kHz
// - interval used only under immediate trigger
// - too fast rate gives back to back
// - gated mode output follows gate level
// - gating ignores count, rate, phase, source
// - internal burst source means triggered mode
// - only one modulation mode active at once
// - emit count cycles then hold at offset
// - immediate default, setup forces it
// - ext rising edge starts burst, shows wait
// - one burst per bus trigger while idle; several triggers during one burst give only one more burst
// - wait command holds until bursts finish
// - burst end answers query, sets event bit
// - reset gives triggered mode, internal source; the code resets active_mode to MODE_NONE
`ifndef BURST_CONSTS_SVH
`define BURST_CONSTS_SVH

`define COUNT_MIN            16'h0001
`define COUNT_MAX            16'hC350
`define COUNT_DEFAULT        16'h0001
`define COUNT_PER_MHZ_LIMIT  16'h0005

// carrier frequency in millihertz
`define FREQ_MIN             33'h00000000A
`define FREQ_MAX             33'h12A05F200
`define FREQ_MAX_TRI         33'h005F5E100
`define FREQ_DEFAULT         33'h0000F4240
`define FREQ_ONE_MHZ         33'h03B9ACA00
`define FREQ_LOW_LIMIT       33'h0000186A0
`define MILLI_PER_UNIT       1000
`define BURST_DURATION_MAX_S 500

// phase in millidegrees
`define PHASE_MAX            20'sh57E40
`define PHASE_MIN            -20'sh57E40
`define PHASE_DEFAULT        20'sh00000

// burst interval limits and default, in their own units
`define CLK_HZ               64'd100000000
`define INTERVAL_MIN_US      64'd20
`define INTERVAL_MAX_S       64'd100
`define INTERVAL_DEFAULT_MS  64'd10

`endif

// ==== rtl/burst_pkg.sv ====
// types for the burst modulation controller
package burst_pkg;

  typedef enum logic [2:0] {SHAPE_SINE, SHAPE_SQUARE, SHAPE_TRI, SHAPE_RAMP, SHAPE_ARB}
    shape_type;
  typedef enum logic [1:0] {TRIG_IMMEDIATE, TRIG_EXTERNAL, TRIG_BUS} trig_source_type;
  typedef enum logic {GATE_INTERNAL, GATE_EXTERNAL} gate_source_type;
  typedef enum logic [2:0] {MODE_NONE, MODE_AM, MODE_FM, MODE_FSK, MODE_SWEEP, MODE_BURST}
    mod_mode_type;

  typedef struct packed {
    logic [1:0] stage;
  } sync_state_type;

  typedef struct packed {
    mod_mode_type    active_mode;
    gate_source_type gate_src;
    trig_source_type trig_src;
    shape_type       shape;
    logic [15:0]     count;
    logic [32:0]     freq;
    logic [19:0]     phase;
    logic [33:0]     interval;
    logic [33:0]     timer;
    logic [15:0]     remaining;
    logic            busy;
    logic            imm_pend;
    logic            bus_pend;
    logic            ext_prev;
    logic            carrier_enable;
    logic            phase_load;
    logic            trig_waiting;
    logic            opc_query_armed;
    logic            opc_cmd_armed;
    logic            opc_reply_valid;
    logic            opc_event;
    logic            wai_armed;
    logic            conflict;
  } burst_state_type;

endpackage

// ==== rtl/sync_two_flop.sv ====
// two flip-flop synchroniser with asynchronous clear
`timescale 1ns/10ps
module sync_two_flop (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // data
  input  wire logic d,
  output logic      q
);
  import burst_pkg::*;

  sync_state_type state;
  sync_state_type next_state;

  always_comb begin
    next_state.stage = {state.stage[0], d};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign q = state.stage[1];
endmodule

// ==== verif/carrier_synth_model.sv ====
// carrier synthesiser stand-in: one done pulse per period
`timescale 1ns/10ps
module carrier_synth_model (
  // clock and reset
  input  logic       clk,
  input  logic       reset_n,
  // carrier control from the block
  input  logic       carrier_enable,
  input  logic       phase_load,
  // clocks per carrier period
  input  logic [7:0] period,
  // end of each carrier cycle
  output logic       carrier_cycle_done
);
  logic [7:0] cnt;

  // a burst start restarts the carrier from the loaded phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 8'h00;
    end else if (phase_load || !carrier_enable || cnt == period - 8'h01) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  assign carrier_cycle_done = carrier_enable && !phase_load && cnt == period - 8'h01;
endmodule

// ==== verif/burst_modulation_control_sva.sv ====
// port checks for the burst modulation controller
`timescale 1ns/10ps
`include "burst_consts.svh"
module burst_modulation_control_sva
  import burst_pkg::*;
#(
  parameter logic [33:0] INTERVAL_MIN_CYCLES = 34'h7D0,
  parameter logic [33:0] INTERVAL_MAX_CYCLES = 34'h2540BE400
) (
  // clock and reset
  input logic                    clk,
  input logic                    reset_n,
  // watched inputs
  input logic                    burst_mode_switch,
  input logic                    burst_mode_on_value,
  input logic                    request_is_remote,
  input logic                    carrier_cycle_done,
  input logic                    wai_command,
  // watched outputs
  input burst_pkg::mod_mode_type active_mode,
  input logic                    carrier_enable,
  input logic                    phase_load,
  input logic [19:0]             start_phase,
  input logic                    phase_ref_first_sample,
  input logic                    trig_waiting,
  input logic                    burst_busy,
  input logic                    command_hold,
  input logic                    settings_conflict,
  input logic [15:0]             burst_cycle_count,
  input logic [32:0]             carrier_frequency,
  input logic [33:0]             burst_interval,
  input burst_pkg::shape_type    carrier_shape
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic        slow;
  assign slow = carrier_shape inside {SHAPE_TRI, SHAPE_RAMP};

  // carrier cycles since burst start
  logic [15:0] done_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_cnt <= 16'h0000;
    end else if (phase_load) begin
      done_cnt <= 16'h0000;
    end else if (burst_busy && carrier_cycle_done) begin
      done_cnt <= done_cnt + 16'h0001;
    end
  end

  sequence s_burst_on;
    burst_mode_switch && burst_mode_on_value;
  endsequence
  sequence s_settled;
    $stable(burst_cycle_count) && $stable(carrier_frequency);
  endsequence

  a_mode_burst_on: assert property (s_burst_on |=> active_mode == MODE_BURST)
    else $error("mode not burst");
  a_count_range: assert property (burst_cycle_count >= `COUNT_MIN &&
    burst_cycle_count <= `COUNT_MAX)
    else $error("count range");
  a_freq_range: assert property (carrier_frequency >= `FREQ_MIN &&
    carrier_frequency <= (slow ? `FREQ_MAX_TRI : `FREQ_MAX))
    else $error("freq range");
  a_count_per_mhz: assert property (s_settled ##0
    (burst_cycle_count < `COUNT_PER_MHZ_LIMIT && !slow) |->
    carrier_frequency <= 33'(burst_cycle_count) * `FREQ_ONE_MHZ)
    else $error("freq above count limit");
  a_low_duration: assert property (s_settled ##0
    carrier_frequency <= `FREQ_LOW_LIMIT |-> carrier_frequency >= 33'(burst_cycle_count) * 33'h2)
    else $error("burst too long");
  a_phase_range: assert property ($signed(start_phase) <= $signed(`PHASE_MAX) &&
    $signed(start_phase) >= $signed(`PHASE_MIN))
    else $error("phase range");
  a_arb_reference: assert property (
    phase_ref_first_sample == (carrier_shape == SHAPE_ARB))
    else $error("phase reference");
  a_interval_range: assert property (burst_interval >= INTERVAL_MIN_CYCLES &&
    burst_interval <= INTERVAL_MAX_CYCLES)
    else $error("interval range");
  a_conflict_remote: assert property (settings_conflict |->
    $past(request_is_remote))
    else $error("local conflict");
  a_burst_start: assert property ($rose(burst_busy) |-> phase_load && carrier_enable)
    else $error("bad burst start");
  a_burst_length: assert property ($fell(burst_busy) |->
    done_cnt == $past(burst_cycle_count))
    else $error("burst length");
  a_wait_idle: assert property (burst_busy && $past(burst_busy) |-> !trig_waiting)
    else $error("waiting while busy");
  a_hold_wai: assert property (wai_command && burst_busy ##1 burst_busy |->
    command_hold)
    else $error("wait not held");
endmodule

bind burst_modulation_control burst_modulation_control_sva #(
  .INTERVAL_MIN_CYCLES(INTERVAL_MIN_CYCLES),
  .INTERVAL_MAX_CYCLES(INTERVAL_MAX_CYCLES)
) burst_modulation_control_sva_inst (.*);

// ==== verif/tb_burst_modulation_control.sv ====
// self-checking testbench for the burst modulation controller
`timescale 1ns/10ps
module tb_burst_modulation_control;
  import burst_pkg::*;
  typedef struct packed {
    logic [1:0]  kind;
    logic [33:0] val;
    shape_type   shape;
    logic        remote;
    logic [33:0] exp;
    logic        conf;
  } row_type;
  logic            clk, reset_n, remote, on, pin, carrier_cycle_done;
  logic [13:0]     stb;
  logic [33:0]     v;
  logic [7:0]      period;
  shape_type       shape, carrier_shape;
  gate_source_type gsrc;
  trig_source_type tsrc;
  mod_mode_type    omode, active_mode;
  logic            carrier_enable, phase_load, phase_ref_first_sample, trig_waiting;
  logic            burst_busy, command_hold, opc_reply_valid, opc_event, settings_conflict;
  logic [15:0]     burst_cycle_count;
  logic [19:0]     start_phase;
  logic [32:0]     carrier_frequency;
  logic [33:0]     burst_interval;
  int              error_cnt, n_compared, bursts, replies;
  // kind 0 count, 1 carrier, 2 phase, 3 interval; each row builds on the last
  row_type rows[18] = '{
    '{2'h1, 34'h165A0BC00, SHAPE_SINE, 1'h0, 34'h03B9ACA00, 1'h0},
    '{2'h0, 34'h2, SHAPE_SINE, 1'h0, 34'h2, 1'h0},
    '{2'h1, 34'h165A0BC00, SHAPE_SINE, 1'h1, 34'h077359400, 1'h1},
    '{2'h1, 34'h011E1A300, SHAPE_TRI, 1'h1, 34'h005F5E100, 1'h0},
    '{2'h0, 34'h0, SHAPE_SINE, 1'h0, 34'h1, 1'h0},
    '{2'h0, 34'hEA60, SHAPE_SINE, 1'h0, 34'hC350, 1'h0},
    '{2'h1, 34'hC350, SHAPE_SINE, 1'h1, 34'h186A0, 1'h1},
    '{2'h1, 34'h5, SHAPE_ARB, 1'h0, 34'h186A0, 1'h0},
    '{2'h0, 34'h3, SHAPE_SINE, 1'h0, 34'h3, 1'h0},
    '{2'h1, 34'h0EE6B2800, SHAPE_SQUARE, 1'h1, 34'h0B2D05E00, 1'h1},
    '{2'h0, 34'h5, SHAPE_SINE, 1'h0, 34'h5, 1'h0},
    '{2'h1, 34'h12A05F200, SHAPE_ARB, 1'h1, 34'h12A05F200, 1'h0},
    '{2'h2, 34'h61A80, SHAPE_SINE, 1'h0, 34'h57E40, 1'h0},
    '{2'h2, 34'h9E580, SHAPE_SINE, 1'h0, 34'hA81C0, 1'h0},
    '{2'h2, 34'h4D2, SHAPE_SINE, 1'h0, 34'h4D2, 1'h0},
    '{2'h3, 34'h5, SHAPE_SINE, 1'h0, 34'h14, 1'h0},
    '{2'h3, 34'h1F4, SHAPE_SINE, 1'h0, 34'hC8, 1'h0},
    '{2'h3, 34'h32, SHAPE_SINE, 1'h0, 34'h32, 1'h0}};

  burst_modulation_control #(
    .INTERVAL_MIN_CYCLES(34'h14), .INTERVAL_MAX_CYCLES(34'hC8), .INTERVAL_DEFAULT_CYCLES(34'h64)
  ) burst_modulation_control_inst (
    .*, .set_burst_cycle_count(stb[0]), .burst_cycle_count_value(v[15:0]),
    .set_burst_start_phase(stb[2]), .burst_start_phase_value(v[19:0]),
    .set_internal_burst_interval(stb[3]), .burst_interval_value(v), .set_carrier(stb[1]),
    .carrier_frequency_value(v[32:0]), .carrier_shape_value(shape), .request_is_remote(remote),
    .select_burst_gate_source(stb[4]), .gate_source_value(gsrc), .set_trigger_source(stb[5]),
    .trigger_source_value(tsrc), .burst_mode_switch(stb[6]), .burst_mode_on_value(on),
    .enable_other_mode(stb[7]), .other_mode_value(omode), .apply_setup(stb[8]),
    .ext_trigger_pin(pin), .bus_trigger(stb[9]), .opc_query(stb[10]),
    .opc_command(stb[11]), .wai_command(stb[12]), .opc_event_clear(stb[13]));

  carrier_synth_model carrier_synth_model_inst (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (phase_load === 1'b1) bursts++;
    if (opc_reply_valid === 1'b1) replies++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(input int a, input int b = -1);
    tick(1);
    stb[a] = 1'b1;
    if (b >= 0) stb[b] = 1'b1;
    tick(1);
    stb = '0;
  endtask

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (burst_busy !== lvl && n < 600) begin
      tick(1);
      n++;
    end
    chk("burst_busy", 34'(lvl), 34'(burst_busy));
  endtask

  function automatic logic [33:0] got(input logic [1:0] k);
    case (k)
      2'h0: got = 34'(burst_cycle_count);
      2'h1: got = 34'(carrier_frequency);
      2'h2: got = 34'(start_phase);
      default: got = burst_interval;
    endcase
  endfunction

  task automatic do_reset();
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(3);
    chk("count", 34'h1, 34'(burst_cycle_count));
    chk("freq", 34'hF4240, 34'(carrier_frequency));
    chk("phase", 34'h0, 34'(start_phase));
    chk("interval", 34'h64, burst_interval);
    chk("mode", 34'(MODE_NONE), 34'(active_mode));
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // tests need about 1200 cycles; the limit lies at 10000
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    reset_n = 1'b0;
    stb = '0;
    v = '0;
    period = 8'h02;
    {remote, on, pin} = 3'h0;
    shape = SHAPE_SINE;
    gsrc = GATE_INTERNAL;
    tsrc = TRIG_IMMEDIATE;
    omode = MODE_NONE;
    do_reset();
    on = 1'b1;
    pulse(6);
    chk("mode", 34'(MODE_BURST), 34'(active_mode));
    wait_busy(1'b1);
    tsrc = TRIG_BUS;
    pulse(5);
    wait_busy(1'b0);
    $display("test reset done");
    foreach (rows[i]) begin
      v = rows[i].val;
      shape = rows[i].shape;
      remote = rows[i].remote;
      pulse(int'(rows[i].kind));
      chk("setting", rows[i].exp, got(rows[i].kind));
      chk("conflict", 34'(rows[i].conf), 34'(settings_conflict));
    end
    $display("test settings done");
    v = 34'hF4240;
    shape = SHAPE_SINE;
    remote = 1'b0;
    pulse(1);
    v = 34'h3;
    pulse(0);
    bursts = 0;
    replies = 0;
    pulse(9);
    pulse(12);
    chk("hold", 34'h1, 34'(command_hold));
    pulse(10);
    wait_busy(1'b0);
    tick(2);
    chk("hold", 34'h0, 34'(command_hold));
    chk("carrier", 34'h0, 34'(carrier_enable));
    chk("replies", 34'h1, 34'(replies));
    pulse(9);
    pulse(12);
    wait_busy(1'b0);
    tick(2);
    chk("bursts", 34'h2, 34'(bursts));
    pulse(11);
    tick(1);
    chk("opc_event", 34'h1, 34'(opc_event));
    pulse(13);
    tick(1);
    chk("opc_event", 34'h0, 34'(opc_event));
    $display("test bus trigger done");
    tsrc = TRIG_EXTERNAL;
    period = 8'h06;
    pulse(5);
    tick(2);
    chk("waiting", 34'h1, 34'(trig_waiting));
    bursts = 0;
    pin = 1'b1;
    wait_busy(1'b1);
    pin = 1'b0;
    tick(3);
    pin = 1'b1;
    wait_busy(1'b0);
    tick(8);
    chk("bursts", 34'h1, 34'(bursts));
    pin = 1'b0;
    $display("test external trigger done");
    gsrc = GATE_EXTERNAL;
    pulse(4);
    pin = 1'b1;
    tick(6);
    chk("carrier", 34'h1, 34'(carrier_enable));
    chk("busy", 34'h0, 34'(burst_busy));
    chk("waiting", 34'h0, 34'(trig_waiting));
    pin = 1'b0;
    tick(6);
    chk("carrier", 34'h0, 34'(carrier_enable));
    $display("test gated done");
    gsrc = GATE_INTERNAL;
    pulse(4);
    v = 34'h1E;
    period = 8'h0A;
    pulse(3);
    tsrc = TRIG_BUS;
    pulse(5, 8);
    bursts = 0;
    tick(200);
    chk("fast bursts", 34'h1, 34'(bursts >= 5 && bursts <= 7));
    chk("interval", 34'h1E, burst_interval);
    v = 34'hC8;
    period = 8'h01;
    pulse(3);
    tick(40);
    bursts = 0;
    tick(450);
    chk("slow bursts", 34'h1, 34'(bursts >= 1 && bursts <= 3));
    pulse(5);
    wait_busy(1'b0);
    bursts = 0;
    tick(250);
    chk("bursts", 34'h0, 34'(bursts));
    $display("test internal rate done");
    omode = MODE_FM;
    pulse(7);
    chk("mode", 34'(MODE_FM), 34'(active_mode));
    tick(1);
    chk("carrier", 34'h1, 34'(carrier_enable));
    pulse(7, 6);
    chk("mode", 34'(MODE_BURST), 34'(active_mode));
    on = 1'b0;
    pulse(6);
    chk("mode", 34'(MODE_NONE), 34'(active_mode));
    $display("test modes done");
    do_reset();
    $display("test second reset done");
    give_verdict();
  end
endmodule
